// >>> pkg/spi_port_map.svh
// Register map, field positions, reset values and timing counts of the SPI port
// What this block does
// - Polarity bit 0 rests the serial clock high; 1 rests it low.
// - Edge bit picks capture edge: leading when 1, trailing when 0.
// - Bit order 1 shifts most significant bit first, 0 least significant first.
// - Select enable 1 gives the select pin to the port; 0 releases it.
// - Data write during a transfer sets the write collision flag.
// - Data write during a transfer is dropped; the shifting byte is untouched.
// - Collision detection works only while the shared enable bit is set.
// - Transfer complete flag sets itself at the end of every byte.
// - Transfer complete can raise the processor interrupt.
// - Role field codes 0 to 4 select master clock sources; 5 selects slave.
// - Port enable cleared removes serial function from all four lines.
// - In master role a data write starts one full duplex byte.
// - In slave role external clocks shift data out and in.
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL0 8'h00
`define OFS_CTRL1 8'h04
`define OFS_DATA 8'h08
`define OFS_SHARED 8'h0c
`define OFS_STAT 8'h10
`define OFS_MASK 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define B_EN 1
`define B_POL 5
`define B_EDGE 4
`define B_ORDER 3
`define B_SELEN 2
`define B_WCOL 1
`define B_TRF 0
`define B_COLLEN 0

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define RST_CTRL0 8'he0
`define RST_SHARED 8'h00
`define WM_CTRL0 8'he2
`define WM_SHARED 8'hb1

// ----------------------------------------
// Timing counts (system cycles per half serial clock), last edge and bit indices, bus response codes
// ----------------------------------------
`define HALF_DIV4 6'h02
`define HALF_DIV16 6'h08
`define HALF_DIV64 6'h20
`define LAST_EDGE 4'hf
`define LAST_BIT 4'h7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> pkg/spi_port_pkg.sv
// Types shared by the SPI port modules
package spi_port_pkg;

  // Role and clock source codes
  typedef enum logic [2:0]
  {
    ROLE_M_DIV4 = 3'h0,
    ROLE_M_DIV16 = 3'h1,
    ROLE_M_DIV64 = 3'h2,
    ROLE_M_SLOW = 3'h3,
    ROLE_M_TIMER = 3'h4,
    ROLE_SLAVE = 3'h5,
    ROLE_RSV6 = 3'h6,
    ROLE_RSV7 = 3'h7
  } role_t;

  // Master transfer states
  typedef enum logic [0:0]
  {
    XF_IDLE = 1'h0,
    XF_SHIFT = 1'h1
  } xfer_t;

endpackage

// >>> hdl/spi_clk_div.sv
// Half-period enable generator for the master serial clock
`include "spi_port_map.svh"
module spi_clk_div
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Control
  input wire logic i_run,
  input wire spi_port_pkg::role_t i_role,
  // External rate sources
  input wire logic i_slow_tick,
  input wire logic i_timer_tick,
  // Half-period enable
  output logic o_tick
);
  import spi_port_pkg::*;

  logic [5:0] count_r;
  logic [5:0] half;

  // Half period length of the divided system clock
  always_comb
  begin
    case (i_role)
      ROLE_M_DIV4: half = `HALF_DIV4;
      ROLE_M_DIV16: half = `HALF_DIV16;
      default: half = `HALF_DIV64;
    endcase
  end

  // Counter restarts with each byte so the first edge is a full half period away
  // clock source select
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      count_r <= 6'h00;
      o_tick <= 1'h0;
    end
    else if (!i_run)
    begin
      count_r <= 6'h00;
      o_tick <= 1'h0;
    end
    else
    begin
      case (i_role)
        ROLE_M_DIV4, ROLE_M_DIV16, ROLE_M_DIV64:
        begin
          o_tick <= (count_r == half - 6'h01);
          count_r <= (count_r == half - 6'h01) ? 6'h00 : count_r + 6'h01;
        end
        ROLE_M_SLOW: o_tick <= i_slow_tick;
        ROLE_M_TIMER: o_tick <= i_timer_tick; // One toggle per match halves it
        default: o_tick <= 1'h0;
      endcase
    end
  end

endmodule // spi_clk_div

// >>> hdl/spi_port_ctrl.sv
// SPI port with AXI4-Lite registers, master and slave shifter and interrupt
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`include "spi_port_map.svh"
module spi_port_ctrl
(
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  // AXI4-Lite write
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  // AXI4-Lite read
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // Master rate sources
  input wire logic I_SLOW_TICK,
  input wire logic I_TIMER_TICK,
  // Serial lines
  input wire logic I_SCK,
  output logic O_SCK,
  output logic O_SCK_OE_N,
  input wire logic I_SS_N,
  output logic O_SS_N,
  output logic O_SS_OE_N,
  input wire logic I_SDI,
  output logic O_SDO,
  output logic O_SDO_OE_N,
  // Pin function and interrupt
  output logic O_PORT_ACTIVE,
  output logic O_SS_ACTIVE,
  output logic O_IRQ
);
  import spi_port_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `OFS_CTRL0) || (a == `OFS_CTRL1) || (a == `OFS_DATA) ||
             (a == `OFS_SHARED) || (a == `OFS_STAT) || (a == `OFS_MASK);
  endfunction

  function automatic logic [7:0] order(input logic [7:0] d, input logic msb);
    order = msb ? d : {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]};
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic aw_hold_r, w_hold_r;
  logic [7:0] aw_addr_r, w_data_r;
  logic w_strb_r;
  logic [7:0] ctrl0_r, shared_r, data_r, shift_r, rd_val;
  logic pol_r, edge_r, order_r, selen_r, wcol_r, trf_r;
  logic [1:0] stat_r, mask_r;
  xfer_t state_r;
  logic [3:0] edge_cnt_r, bits_r;
  logic sck_r, sdo_r, sck_prev_r, ss_n_r, irq_r;
  logic wr_fire, wr_en, rd_fire, data_wr, ctrl1_wr;
  logic en, is_master, is_slave, idle_lvl, busy, load;
  logic coll_ev, done_ev, tick, m_edge, m_capture, s_sel, s_edge, s_capture;
  logic capture, launch, cap_last;
  role_t role;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // role decode
  assign role = role_t'(ctrl0_r[7:5]);
  assign is_master = (role <= ROLE_M_TIMER);
  assign is_slave = (role == ROLE_SLAVE);
  assign en = ctrl0_r[`B_EN];
  assign idle_lvl = ~pol_r;
  assign wr_fire = aw_hold_r & w_hold_r & ~O_BVALID;
  assign wr_en = wr_fire & w_strb_r & mapped(aw_addr_r);
  assign rd_fire = I_ARVALID & O_ARREADY;
  assign data_wr = wr_en & (aw_addr_r == `OFS_DATA);
  assign ctrl1_wr = wr_en & (aw_addr_r == `OFS_CTRL1);
  assign busy = (state_r == XF_SHIFT) | (is_slave & (bits_r != 4'h0));
  assign load = data_wr & ~busy & en;
  assign coll_ev = data_wr & busy & shared_r[`B_COLLEN];

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  // Address and data taken in either order, response after both
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      aw_hold_r <= 1'h0;
      w_hold_r <= 1'h0;
      aw_addr_r <= 8'h00;
      w_data_r <= 8'h00;
      w_strb_r <= 1'h0;
      O_AWREADY <= 1'h1;
      O_WREADY <= 1'h1;
      O_BVALID <= 1'h0;
      O_BRESP <= `RESP_OKAY;
    end
    else
    begin
      if (I_AWVALID && O_AWREADY)
      begin
        aw_hold_r <= 1'h1;
        aw_addr_r <= I_AWADDR;
        O_AWREADY <= 1'h0;
      end
      if (I_WVALID && O_WREADY)
      begin
        w_hold_r <= 1'h1;
        w_data_r <= I_WDATA[7:0];
        w_strb_r <= I_WSTRB[0];
        O_WREADY <= 1'h0;
      end
      if (wr_fire)
      begin
        aw_hold_r <= 1'h0;
        w_hold_r <= 1'h0;
        O_BVALID <= 1'h1;
        O_BRESP <= mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (O_BVALID && I_BREADY)
      begin
        O_BVALID <= 1'h0;
        O_AWREADY <= 1'h1;
        O_WREADY <= 1'h1;
      end
    end
  end

  // Read value mux
  always_comb
  begin
    case (I_ARADDR)
      `OFS_CTRL0: rd_val = ctrl0_r;
      `OFS_CTRL1: rd_val = {2'h0, pol_r, edge_r, order_r, selen_r, wcol_r, trf_r};
      `OFS_DATA: rd_val = data_r;
      `OFS_SHARED: rd_val = shared_r;
      `OFS_STAT: rd_val = {6'h00, stat_r};
      `OFS_MASK: rd_val = {6'h00, mask_r};
      default: rd_val = 8'h00;
    endcase
  end

  // Read channel, one cycle to data
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      O_ARREADY <= 1'h1;
      O_RVALID <= 1'h0;
      O_RDATA <= 32'h0000_0000;
      O_RRESP <= `RESP_OKAY;
    end
    else if (rd_fire)
    begin
      O_ARREADY <= 1'h0;
      O_RVALID <= 1'h1;
      O_RDATA <= {24'h00_0000, rd_val};
      O_RRESP <= mapped(I_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (O_RVALID && I_RREADY)
    begin
      O_RVALID <= 1'h0;
      O_ARREADY <= 1'h1;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // settings take effect at once, software orders them
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      ctrl0_r <= `RST_CTRL0;
      shared_r <= `RST_SHARED;
      mask_r <= 2'h0;
      {pol_r, edge_r, order_r, selen_r} <= 4'h0;
    end
    else if (wr_en)
    begin
      case (aw_addr_r)
        `OFS_CTRL0: ctrl0_r <= w_data_r & `WM_CTRL0;
        `OFS_SHARED: shared_r <= w_data_r & `WM_SHARED;
        `OFS_MASK: mask_r <= w_data_r[1:0];
        `OFS_CTRL1:
        begin
          pol_r <= w_data_r[`B_POL];
          edge_r <= w_data_r[`B_EDGE];
          order_r <= w_data_r[`B_ORDER];
          selen_r <= w_data_r[`B_SELEN];
        end
        default: mask_r <= mask_r;
      endcase
    end
  end

  // ----------------------------------------
  // Flags, status and interrupt
  // ----------------------------------------
  // hardware set wins over software write
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      wcol_r <= 1'h0;
      trf_r <= 1'h0;
    end
    else
    begin
      if (coll_ev)
        wcol_r <= 1'h1;
      else if (ctrl1_wr)
        wcol_r <= w_data_r[`B_WCOL];
      if (done_ev)
        trf_r <= 1'h1;
      else if (ctrl1_wr)
        trf_r <= w_data_r[`B_TRF];
    end
  end

  // sticky status cleared by read, masked onto the interrupt line
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      stat_r <= 2'h0;
      irq_r <= 1'h0;
    end
    else
    begin
      stat_r <= ((rd_fire && I_ARADDR == `OFS_STAT) ? 2'h0 : stat_r) | {coll_ev, done_ev};
      irq_r <= |(stat_r & mask_r);
    end
  end
  assign O_IRQ = irq_r;

  // ----------------------------------------
  // Serial engine
  // ----------------------------------------
  spi_clk_div u_div
  (
    .i_clk(I_REF_CLK),
    .i_rstn(I_RSTN),
    .i_run(en & is_master & (state_r == XF_SHIFT)),
    .i_role(role),
    .i_slow_tick(I_SLOW_TICK),
    .i_timer_tick(I_TIMER_TICK),
    .o_tick(tick)
  );

  // even edges lead, capture edge chosen by the edge bit
  assign m_edge = (state_r == XF_SHIFT) & tick;
  assign m_capture = m_edge & (~edge_cnt_r[0] == edge_r);
  // slave edges come from the external clock while selected
  assign s_sel = en & is_slave & (~selen_r | ~I_SS_N);
  assign s_edge = s_sel & (I_SCK != sck_prev_r);
  assign s_capture = s_edge & ((sck_prev_r == idle_lvl) == edge_r);
  assign capture = m_capture | s_capture;
  assign launch = (m_edge & ~m_capture) | (s_edge & ~s_capture);
  assign cap_last = capture & (bits_r == `LAST_BIT);
  assign done_ev = is_master ? (m_edge & (edge_cnt_r == `LAST_EDGE)) : (s_sel & cap_last);

  // Master sequencer
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      state_r <= XF_IDLE;
      edge_cnt_r <= 4'h0;
    end
    else if (!(en && is_master))
      state_r <= XF_IDLE;
    else
    begin
      case (state_r)
        XF_IDLE:
        begin
          edge_cnt_r <= 4'h0;
          if (load)
            state_r <= XF_SHIFT;
        end
        XF_SHIFT:
        begin
          if (tick)
            edge_cnt_r <= edge_cnt_r + 4'h1;
          if (tick && edge_cnt_r == `LAST_EDGE)
            state_r <= XF_IDLE;
        end
        default: state_r <= XF_IDLE;
      endcase
    end
  end

  // clock rests at idle level unless a byte is shifting
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      sck_r <= 1'h1;
    else if (state_r != XF_SHIFT)
      sck_r <= ctrl1_wr ? ~w_data_r[`B_POL] : idle_lvl; // New polarity shows at once
    else if (tick)
      sck_r <= ~sck_r;
  end

  // shifter loads only when idle, always shifts its top bit
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      shift_r <= 8'h00;
      sdo_r <= 1'h1;
      bits_r <= 4'h0;
      data_r <= 8'h00;
      sck_prev_r <= 1'h1;
    end
    else
    begin
      sck_prev_r <= I_SCK;
      if (load)
      begin
        shift_r <= order(w_data_r, order_r);
        sdo_r <= order_r ? w_data_r[7] : w_data_r[0];
        data_r <= w_data_r;
        bits_r <= 4'h0;
      end
      else
      begin
        if (capture)
          shift_r <= {shift_r[6:0], I_SDI};
        if (launch)
          sdo_r <= shift_r[7];
        if (cap_last)
          data_r <= order({shift_r[6:0], I_SDI}, order_r);
        if (!en || (is_slave && !s_sel) || cap_last)
          bits_r <= 4'h0;
        else if (capture)
          bits_r <= bits_r + 4'h1;
      end
    end
  end

  // pin ownership, enables low while driving
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      O_SCK_OE_N <= 1'h1;
      O_SDO_OE_N <= 1'h1;
      O_SS_OE_N <= 1'h1;
      O_SS_N <= 1'h1;
      O_PORT_ACTIVE <= 1'h0;
      O_SS_ACTIVE <= 1'h0;
      ss_n_r <= 1'h1;
    end
    else
    begin
      O_SCK_OE_N <= ~(en & is_master);
      O_SDO_OE_N <= ~(en & (is_master | is_slave));
      O_SS_OE_N <= ~(en & selen_r & is_master);
      ss_n_r <= ~(is_master & ((state_r == XF_SHIFT) | load));
      O_SS_N <= ss_n_r;
      O_PORT_ACTIVE <= en & (is_master | is_slave);
      O_SS_ACTIVE <= en & selen_r;
    end
  end
  assign O_SCK = sck_r;
  assign O_SDO = sdo_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);

  a_idle_level: assert property
    ((state_r == XF_IDLE) ##1 (state_r == XF_IDLE) |-> O_SCK == idle_lvl)
    else $error("serial clock not at idle level");
  a_collision_set: assert property
    (data_wr && busy && shared_r[`B_COLLEN] |=> wcol_r && stat_r[1])
    else $error("collision not flagged");
  a_collision_off: assert property
    (!shared_r[`B_COLLEN] && !wcol_r && !ctrl1_wr |=> !wcol_r)
    else $error("collision flagged while detection off");
  a_write_dropped: assert property
    (data_wr && busy && !capture |=> shift_r == $past(shift_r))
    else $error("busy write altered shifter");
  a_done_flag: assert property
    (is_master && m_edge && edge_cnt_r == `LAST_EDGE |=> trf_r ##1 O_IRQ == mask_r[0])
    else $error("completion not flagged");
  a_master_start: assert property
    (load && is_master |=> state_r == XF_SHIFT ##1 !O_SS_N)
    else $error("master byte did not start");
  a_first_bit: assert property
    (load |=> O_SDO == (order_r ? $past(w_data_r[7]) : $past(w_data_r[0])))
    else $error("wrong first bit order");
  a_select_pin: assert property
    (en && selen_r && is_master ##1 $stable(ctrl0_r) && $stable(selen_r) |-> !O_SS_OE_N)
    else $error("select pin not driven");
  a_port_off: assert property
    (!en ##1 !en |-> O_SCK_OE_N && O_SDO_OE_N && O_SS_OE_N && !O_PORT_ACTIVE)
    else $error("lines driven while disabled");

  c_master_byte: cover property (is_master && done_ev);
  c_slave_byte: cover property (is_slave && done_ev);
  c_collision: cover property (coll_ev);
  c_irq: cover property (O_IRQ);

endmodule // spi_port_ctrl

// >>> tb/spi_slave_model.sv
// Behavioural slave device on the far side of the serial link
module spi_slave_model
(
  // Serial lines
  input wire logic i_sck,
  input wire logic i_ss_n,
  input wire logic i_sdo,
  output logic o_sdi,
  // Mode and data
  input wire logic i_pol,
  input wire logic i_edge,
  input wire logic i_msb,
  input wire logic [7:0] i_tx,
  output logic [7:0] o_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;
  logic started;
  initial o_rx = 8'h00;
  initial o_sdi = 1'b1;
  // Load first bit on select, release by inverting the last value
  always @(i_ss_n)
  begin
    sh = i_tx;
    started = 1'b0;
    o_sdi = i_ss_n ? ~o_sdi : (i_msb ? i_tx[7] : i_tx[0]);
  end
  always @(i_sck)
  begin
    if (!i_ss_n && ((i_sck == i_pol) == i_edge))
    begin
      o_rx = i_msb ? {o_rx[6:0], i_sdo} : {i_sdo, o_rx[7:1]};
      started = 1'b1;
    end
    else if (!i_ss_n && started)
    begin
      sh = i_msb ? sh << 1 : sh >> 1;
      o_sdi = i_msb ? sh[7] : sh[0];
    end
  end
endmodule // spi_slave_model

// >>> tb/testbench.sv
// Self-checking bench for the SPI port control and status block
`include "spi_port_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, slow, tmr, awready, wready;
  logic sck_in, ss_in_n, sdi_tb, m_sdi, sck, sck_oe_n, ss_n, ss_oe_n, sdo, sdo_oe_n;
  logic port_act, ss_act, irq, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, m_tx, m_rx, cfg, got;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  int err_total, tests_run, cycles;
  typedef struct packed {logic [7:0] a; logic [7:0] v; logic [7:0] e; logic [1:0] r;} row_t;
  row_t rows [5];
  logic [7:0] cfgs [5];
  wire sdi_mux = ss_in_n ? m_sdi : sdi_tb;

  spi_port_ctrl dut_u (.I_REF_CLK(clk), .I_RSTN(rstn), .I_AWADDR(awaddr),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_SLOW_TICK(slow), .I_TIMER_TICK(tmr), .I_SCK(sck_in), .O_SCK(sck),
    .O_SCK_OE_N(sck_oe_n), .I_SS_N(ss_in_n), .O_SS_N(ss_n), .O_SS_OE_N(ss_oe_n),
    .I_SDI(sdi_mux), .O_SDO(sdo), .O_SDO_OE_N(sdo_oe_n), .O_PORT_ACTIVE(port_act),
    .O_SS_ACTIVE(ss_act), .O_IRQ(irq));
  spi_slave_model slave_u (.i_sck(sck), .i_ss_n(ss_n), .i_sdo(sdo), .o_sdi(m_sdi),
    .i_pol(cfg[`B_POL]), .i_edge(cfg[`B_EDGE]), .i_msb(cfg[`B_ORDER]), .i_tx(m_tx),
    .o_rx(m_rx));

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Rate ticks and watchdog
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    slow <= (cycles % 3 == 0);
    tmr <= cycles[0];
    if (cycles == 20000)
    begin
      err_total++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clk); while (!bvalid);
    r = bresp; // Ready stays high so no call drives it twice in one step
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp; // Ready stays high between calls
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK({r, d}, {`RESP_OKAY, 24'h0, e})
  endtask
  // One master byte, optional colliding write, then service of the flags
  task automatic xfer(input logic [7:0] tx, input logic [7:0] st, input logic col,
    input logic [7:0] sx);
    int n;
    m_tx = st;
    wr(`OFS_DATA, tx);
    if (col) wr(`OFS_DATA, ~tx);
    n = 0;
    do
    begin
      rd(`OFS_CTRL1);
      n++;
    end
    while (d[`B_TRF] !== 1'b1 && n < 400);
    cyc(3);
    `CHK(d[`B_WCOL], sx[1])
    `CHK(m_rx, tx)
    rchk(`OFS_DATA, st);
    `CHK(irq, 1'b1)
    rchk(`OFS_STAT, sx);
    rchk(`OFS_STAT, 8'h00);
    cyc(2);
    `CHK(irq, 1'b0)
    wr(`OFS_CTRL1, cfg);
    rchk(`OFS_CTRL1, cfg);
    `CHK({sck, ss_n}, {~cfg[`B_POL], 1'b1})
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, slow, tmr} = 8'h00;
    {sck_in, ss_in_n, sdi_tb, awaddr, araddr, wdata} = {3'h7, 48'h0};
    {m_tx, cfg, err_total, tests_run, cycles} = '0;
    rows = '{'{`OFS_CTRL0, 8'hff, 8'he2, `RESP_OKAY}, '{`OFS_SHARED, 8'hff, 8'hb1, `RESP_OKAY},
      '{`OFS_MASK, 8'h03, 8'h03, `RESP_OKAY}, '{`OFS_CTRL1, 8'h1c, 8'h1c, `RESP_OKAY},
      '{8'h18, 8'h5a, 8'h00, `RESP_SLVERR}};
    cfgs = '{8'h1c, 8'h04, 8'h14, 8'h24, 8'h3c};
    cyc(8);
    rstn <= 1'b1;
    @(posedge clk);
    `CHK({sck, port_act, irq}, 3'h4)
    rchk(`OFS_CTRL0, `RST_CTRL0);
    rchk(`OFS_CTRL1, 8'h00);
    rchk(`OFS_SHARED, `RST_SHARED);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].v);
      `CHK(r, rows[i].r)
      rd(rows[i].a);
      `CHK({r, d}, {rows[i].r, 24'h0, rows[i].e})
    end
    `CHK(port_act, 1'b0)
    for (int i = 0; i < 5; i++)
    begin
      cfg = cfgs[i];
      wr(`OFS_CTRL1, cfg);
      wr(`OFS_CTRL0, {i[2:0], 5'h02});
      cyc(2);
      `CHK({sck, port_act}, {~cfg[`B_POL], 1'b1})
      xfer(8'ha5 ^ i[7:0], 8'h3c + i[7:0], 1'b0, 8'h01);
    end
    cfg = 8'h1c;
    wr(`OFS_CTRL1, cfg);
    wr(`OFS_CTRL0, 8'h02);
    xfer(8'h81, 8'h42, 1'b1, 8'h03);
    wr(`OFS_SHARED, 8'h00);
    xfer(8'h18, 8'h24, 1'b1, 8'h01);
    wr(`OFS_CTRL1, 8'h18);
    cyc(2);
    `CHK({ss_act, ss_oe_n}, 2'h1)
    wr(`OFS_CTRL1, 8'h1c);
    cyc(2);
    `CHK({ss_act, ss_oe_n}, 2'h2)
    wr(`OFS_CTRL0, 8'h00);
    wr(`OFS_DATA, 8'h55);
    cyc(40);
    `CHK({port_act, sck_oe_n, sdo_oe_n, ss_oe_n}, 4'h7)
    rchk(`OFS_CTRL1, 8'h1c);
    // Slave byte clocked by the bench, capture on the leading edge
    wr(`OFS_CTRL0, 8'ha2);
    wr(`OFS_DATA, 8'h96);
    ss_in_n <= 1'b0;
    for (int b = 7; b >= 0; b--)
    begin
      sdi_tb <= 8'hc3 >> b;
      cyc(3);
      got[b] = sdo;
      sck_in <= 1'b0;
      cyc(3);
      sck_in <= 1'b1;
    end
    cyc(3);
    ss_in_n <= 1'b1;
    sdi_tb <= ~sdi_tb;
    `CHK(got, 8'h96)
    rchk(`OFS_DATA, 8'hc3);
    rchk(`OFS_STAT, 8'h01);
    // Reset in mid-byte returns lines and registers to their rest values
    wr(`OFS_CTRL0, 8'h02);
    wr(`OFS_DATA, 8'h5a);
    cyc(10);
    rstn <= 1'b0;
    cyc(2);
    `CHK({sck, ss_n, sdo, sck_oe_n, port_act, irq}, 6'h3c)
    rstn <= 1'b1;
    cyc(1);
    rchk(`OFS_CTRL0, `RST_CTRL0);
    rchk(`OFS_STAT, 8'h00);
    end_sim();
  end
endmodule // testbench
